// >>> logic/bsrs_pkg.sv
package bsrs_pkg;
  // Clock and times.
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BOOT_TIME_US = 3000;
  localparam int unsigned BOOT_CYC = BOOT_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned START_TIME_MS = 200;
  localparam int unsigned START_CYC = START_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_TIME_MS = 200;
  localparam int unsigned WAKE_CYC = WAKE_TIME_MS * (CLK_HZ / 1000);
  // Strap encodings.
  localparam logic [1:0] BOOT_HOSTPORT = 2'h0;
  localparam logic [1:0] BOOT_FASTSER = 2'h1;
  localparam logic [1:0] BOOT_SPI = 2'h2;
  localparam logic [1:0] BOOT_EEPROM = 2'h3;
  // Memory map.
  localparam logic [15:0] SYSVAR_LAST = 16'h04a2;
  localparam logic [15:0] CTRL_FIRST = 16'hc000;
  localparam logic [15:0] CTRL_LAST = 16'hc0ff;
  localparam logic [15:0] ROM_FIRST = 16'he000;
  localparam logic [15:0] START_ADDR = 16'hff00;
  localparam logic [15:0] JUMP_ADDR = 16'he000;
  localparam logic [15:0] CPU_SPEED_ADDR = 16'hc008;
  localparam logic [15:0] PWR_CTRL_ADDR = 16'hc00a;
  localparam logic [15:0] OTG_CTRL_ADDR = 16'hc098;
  localparam logic [15:0] USBRST_A_ADDR = 16'hc090;
  localparam logic [15:0] USBRST_B_ADDR = 16'hc0b0;
  localparam int unsigned SLEEP_BIT = 1;
  localparam logic [3:0] CPU_SPEED_RST = 4'hf;
  // Host port address selects.
  localparam logic [1:0] HP_DATA = 2'h0;
  localparam logic [1:0] HP_MAILBOX = 2'h1;
  localparam logic [1:0] HP_ADDRPTR = 2'h2;
  localparam logic [1:0] HP_STATUS = 2'h3;
  // Pin groups.
  localparam logic [31:0] TEST_OUT_MASK = 32'h01f8ff00;
  localparam logic [31:0] UART_MASK = 32'h18000000;
  localparam logic [31:0] STRAP_MASK = 32'hc0000000;
  localparam int unsigned OTG_IDENTITY_PIN_PIN = 29;

  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_START = 5'h02,
    ST_BOOT = 5'h04,
    ST_RUN = 5'h08,
    ST_SLEEP = 5'h10
  } bsrs_state_type;

  typedef enum logic [1:0] {
    REG_OTHER = 2'h0,
    REG_SYSVAR = 2'h1,
    REG_CTRL = 2'h2,
    REG_ROM = 2'h3
  } bsrs_region_type;
endpackage

// >>> logic/bsrs_seq.sv
`timescale 1ns/1ps
// Overview of operation
// - Latch two strap pins at reset release.
// - Strap 00 hostport, 01 serial, 10 SPI, 11 EEPROM.
// - Straps examined only in the cycle after reset release, before the 200 ms wait and 3 ms boot.
// - Non-standalone: coprocessor mode, one interface enabled.
// - Loading starts only after boot window ends.
// - Standalone drives straps, enables debug UART pins.
// - Pin 29 picks first port role.
// - Other ports peripheral, other pins inputs.
// - Sleep bit 1 of 0xC00A enters sleep.
// - Sleep keeps pins, stops clocks, memory address low.
// - Speed register slows only processor clock.
// - Enabled wakeup sources end sleep.
// - Waking host-port read returns dummy data.
// - USB resume raises host port interrupt.
// - After wakeup, resume within 200 ms.
// - Reset defaults; start 0xFF00 after 200 ms.
// - Test pins driven during boot window.
// - USB reset clears only two registers.
// - Memory map regions decoded.
// - Some addresses decode by direction or role.
// - Host port address selects four registers.
module bsrs_seq
  import bsrs_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES = BOOT_CYC,
  parameter int unsigned START_CYCLES = START_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
)
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic NRST,
  // Pins sampled from outside.
  input wire logic [1:0] STRAP_IN,
  input wire logic OTG_IDENTITY_PIN,
  input wire logic OTG_BUS_SUPPLY_PIN,
  input wire logic EXTERNAL_IRQ_LINE,
  input wire logic USB_RESUME,
  input wire logic HOST_READ,
  input wire logic [1:0] HOST_ADDR,
  // Firmware controls.
  input wire logic SLEEP_SET,
  input wire logic [4:0] WAKE_ENABLE,
  input wire logic [3:0] CPU_SPEED,
  input wire logic USB_BUS_RESET,
  input wire logic [15:0] ACCESS_ADDR,
  input wire logic ACCESS_WRITE,
  input wire logic USB_HOST_ROLE,
  // Boot results.
  output logic [1:0] BOOT_MODE,
  output logic BOOT_DONE,
  output logic STANDALONE,
  output logic [2:0] HOST_IF_ENABLE,
  output logic LOAD_ALLOWED,
  output logic [31:0] PIN_OUT_ENABLE_N,
  output logic FIRST_USB_PORT_HOST,
  output logic [2:0] OTHER_PORTS_HOST,
  // Power and processor.
  output logic ASLEEP,
  output logic CLOCKS_ON,
  output logic MEM_ADDR_LOW,
  output logic CPU_RUN,
  output logic CPU_TICK,
  output logic [15:0] START_PC,
  output logic HOST_PORT_IRQ_OUT,
  output logic HOST_READ_DUMMY,
  output logic [3:0] HOST_PORT_SELECT,
  output logic USB_REG_CLEAR,
  output logic [1:0] ACCESS_REGION,
  output logic ACCESS_ALT_DECODE
);
  bsrs_state_type state_r, state_nxt;
  logic [22:0] cnt_r, cnt_nxt;
  logic [1:0] mode_r;
  logic [2:0] id_s0_r, id_s1_r, id_s2_r;
  logic [1:0] st_s0_r, st_s1_r, st_s2_r;
  logic id_r, irq_r, vb_r, first_r;
  logic [3:0] div_r;
  logic irq_out_r, dummy_r;

  function automatic logic agree(input logic a, input logic b, input logic old);
    agree = (a == b) ? a : old;
  endfunction

  // Three-stage synchronisers; only stages two and three are compared.
  // They keep sampling through reset, so the straps have settled by the release edge.
  always_ff @(posedge REF_CLK)
  begin
    st_s0_r <= STRAP_IN;
    st_s1_r <= st_s0_r;
    st_s2_r <= st_s1_r;
    id_s0_r <= {OTG_IDENTITY_PIN, EXTERNAL_IRQ_LINE, OTG_BUS_SUPPLY_PIN};
    id_s1_r <= id_s0_r;
    id_s2_r <= id_s1_r;
  end

  wire id_f = agree(id_s1_r[2], id_s2_r[2], id_r);
  wire irq_f = agree(id_s1_r[1], id_s2_r[1], irq_r);
  wire vb_f = agree(id_s1_r[0], id_s2_r[0], vb_r);
  wire [1:0] strap_f = (st_s1_r == st_s2_r) ? st_s2_r : mode_r;

  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      id_r <= 1'b1;
      irq_r <= 1'b0;
      vb_r <= 1'b0;
    end
    else
    begin
      id_r <= id_f;
      irq_r <= irq_f;
      vb_r <= vb_f;
    end
  end

  // Wakeup events: resume, bus supply level, identity edge, host read, irq edge.
  wire [4:0] wake_ev = {irq_f ^ irq_r, HOST_READ, id_f ^ id_r, vb_f, USB_RESUME};
  wire wake = |(wake_ev & WAKE_ENABLE);
  wire cnt_done = (cnt_r == 23'h0);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r == 23'h0) ? 23'h0 : cnt_r - 23'h1;
    case (state_r)
      ST_RESET:
      begin
        state_nxt = ST_START;
        cnt_nxt = 23'(START_CYCLES - 1);
      end
      ST_START:
        if (cnt_done)
        begin
          state_nxt = ST_BOOT;
          cnt_nxt = 23'(BOOT_CYCLES - 1);
        end
      ST_BOOT:
        if (cnt_done)
          state_nxt = ST_RUN;
      ST_RUN:
        if (SLEEP_SET)
          state_nxt = ST_SLEEP;
      ST_SLEEP:
        if (wake)
        begin
          state_nxt = ST_START;
          cnt_nxt = 23'(WAKE_CYCLES - 1);
        end
      default: state_nxt = ST_RESET;
    endcase
  end

  // A wake reruns the settle wait but skips the boot window, so test pins stay quiet.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      state_r <= ST_RESET;
      cnt_r <= 23'h0;
      first_r <= 1'b1;
    end
    else
    begin
      state_r <= (state_r == ST_START && cnt_done && !first_r) ? ST_RUN : state_nxt;
      cnt_r <= cnt_nxt;
      if (state_r == ST_BOOT)
        first_r <= 1'b0;
    end
  end

  // Straps caught by a clocked process right after reset release, then frozen.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      mode_r <= BOOT_HOSTPORT;
    else if (state_r == ST_RESET)
      mode_r <= strap_f;
  end

  // Processor clock divider; peripheral timing keeps the full clock.
  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
      div_r <= 4'h0;
    else
      div_r <= (div_r >= CPU_SPEED) ? 4'h0 : div_r + 4'h1;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!NRST)
    begin
      irq_out_r <= 1'b0;
      dummy_r <= 1'b0;
    end
    else
    begin
      irq_out_r <= (state_r == ST_SLEEP) && USB_RESUME && WAKE_ENABLE[0];
      dummy_r <= (state_r == ST_SLEEP) && HOST_READ && WAKE_ENABLE[3];
    end
  end

  wire standalone = (mode_r == BOOT_EEPROM);
  wire booting = (state_r == ST_BOOT);
  wire running = (state_r == ST_RUN) || booting;
  wire [31:0] boot_oe = booting ? TEST_OUT_MASK : 32'h0;
  // Standalone pin roles hold through sleep and the wake restart, not only while running.
  wire [31:0] sa_oe = (standalone && !first_r && !booting) ? (STRAP_MASK | UART_MASK) : 32'h0;

  assign BOOT_MODE = mode_r;
  assign BOOT_DONE = (state_r == ST_RUN) || (state_r == ST_SLEEP);
  assign STANDALONE = standalone;
  assign HOST_IF_ENABLE = standalone ? 3'h0 : (3'h1 << mode_r);
  assign LOAD_ALLOWED = !standalone && BOOT_DONE;
  assign PIN_OUT_ENABLE_N = ~(boot_oe | sa_oe);
  assign FIRST_USB_PORT_HOST = standalone && !id_r;
  assign OTHER_PORTS_HOST = 3'h0;
  assign ASLEEP = (state_r == ST_SLEEP);
  assign CLOCKS_ON = !ASLEEP;
  assign MEM_ADDR_LOW = ASLEEP;
  assign CPU_RUN = running;
  assign CPU_TICK = running && (div_r == 4'h0);
  assign START_PC = (state_r == ST_START) ? START_ADDR : JUMP_ADDR;
  assign HOST_PORT_IRQ_OUT = irq_out_r;
  assign HOST_READ_DUMMY = dummy_r;
  assign HOST_PORT_SELECT = 4'h1 << HOST_ADDR;
  wire usb_reg_hit = (ACCESS_ADDR == USBRST_A_ADDR) || (ACCESS_ADDR == USBRST_B_ADDR);
  assign USB_REG_CLEAR = USB_BUS_RESET;
  assign ACCESS_REGION = (ACCESS_ADDR <= SYSVAR_LAST) ? REG_SYSVAR :
                         (ACCESS_ADDR >= CTRL_FIRST && ACCESS_ADDR <= CTRL_LAST) ? REG_CTRL :
                         (ACCESS_ADDR >= ROM_FIRST) ? REG_ROM : REG_OTHER;
  assign ACCESS_ALT_DECODE = (ACCESS_REGION == REG_CTRL) && (ACCESS_WRITE || USB_HOST_ROLE) && !usb_reg_hit;

  // Assertions.
  property p_mode_stable;
    @(posedge REF_CLK) disable iff (!NRST) (state_r != ST_RESET && $past(state_r) != ST_RESET) |-> $stable(mode_r);
  endproperty
  a_mode_stable: assert property (p_mode_stable) else $error("boot mode changed");
  property p_sleep_entry;
    @(posedge REF_CLK) disable iff (!NRST) (state_r == ST_RUN && SLEEP_SET) |=> ASLEEP;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
  property p_sleep_outputs;
    @(posedge REF_CLK) disable iff (!NRST) ASLEEP |-> (!CLOCKS_ON && MEM_ADDR_LOW && !CPU_RUN);
  endproperty
  a_sleep_outputs: assert property (p_sleep_outputs) else $error("sleep outputs wrong");
  property p_wake;
    @(posedge REF_CLK) disable iff (!NRST) (ASLEEP && wake) |=> (state_r == ST_START);
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup missed");
  property p_irq;
    @(posedge REF_CLK) disable iff (!NRST) (ASLEEP && USB_RESUME && WAKE_ENABLE[0]) |=> HOST_PORT_IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq) else $error("resume irq missing");
  property p_coproc;
    @(posedge REF_CLK) disable iff (!NRST) !standalone |-> ($onehot(HOST_IF_ENABLE) && !FIRST_USB_PORT_HOST);
  endproperty
  a_coproc: assert property (p_coproc) else $error("coprocessor interface wrong");
  property p_load;
    @(posedge REF_CLK) disable iff (!NRST) LOAD_ALLOWED |-> !booting && state_r != ST_START;
  endproperty
  a_load: assert property (p_load) else $error("load before boot end");
  property p_test_pins;
    @(posedge REF_CLK) disable iff (!NRST) booting |-> (PIN_OUT_ENABLE_N[8] == 1'b0 && PIN_OUT_ENABLE_N[24] == 1'b0);
  endproperty
  a_test_pins: assert property (p_test_pins) else $error("test pins not driven");
  property p_start_pc;
    @(posedge REF_CLK) disable iff (!NRST) $rose(state_r == ST_START) |-> START_PC == START_ADDR;
  endproperty
  a_start_pc: assert property (p_start_pc) else $error("start address wrong");
  property p_strap_latch;
    @(posedge REF_CLK) disable iff (!NRST) (state_r == ST_RESET) |=> (mode_r == $past(strap_f));
  endproperty
  a_strap_latch: assert property (p_strap_latch) else $error("strap value not latched");
  property p_strap_free;
    @(posedge REF_CLK) disable iff (!NRST) (BOOT_DONE && !standalone) |-> (PIN_OUT_ENABLE_N[31:30] == 2'h3);
  endproperty
  a_strap_free: assert property (p_strap_free) else $error("strap pins still driven");
  property p_pins_kept;
    @(posedge REF_CLK) disable iff (!NRST) (ASLEEP && standalone) |->
      (PIN_OUT_ENABLE_N == ~(STRAP_MASK | UART_MASK));
  endproperty
  a_pins_kept: assert property (p_pins_kept) else $error("pin roles lost in sleep");
  property p_wake_run;
    @(posedge REF_CLK) disable iff (!NRST) (state_r == ST_START && cnt_done && !first_r) |=> (state_r == ST_RUN);
  endproperty
  a_wake_run: assert property (p_wake_run) else $error("no run after wake wait");
  property p_sleep_refused;
    @(posedge REF_CLK) disable iff (!NRST) (state_r == ST_START || booting) |=> !ASLEEP;
  endproperty
  a_sleep_refused: assert property (p_sleep_refused) else $error("sleep entered outside run");
  c_sleep: cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(ASLEEP));
  c_wake: cover property (@(posedge REF_CLK) disable iff (!NRST) ASLEEP && wake);
  c_standalone: cover property (@(posedge REF_CLK) disable iff (!NRST) standalone && BOOT_DONE);
  c_wake_run: cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(CPU_RUN) && !first_r);
  c_load: cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(LOAD_ALLOWED));
endmodule // bsrs_seq

// >>> dv/bsrs_host_model.sv
`timescale 1ns/1ps
module bsrs_host_model
(
  // Clock and device status.
  input wire logic REF_CLK,
  input wire logic LOAD_ALLOWED,
  input wire logic ASLEEP,
  input wire logic HOST_READ_DUMMY,
  // Request from the bench.
  input wire logic READ_REQ,
  // Host port strobe.
  output logic HOST_READ
);
  int dropped = 0;
  // Reads go out only after the boot window, or as a wake poke while the device sleeps.
  always @(posedge REF_CLK)
  begin
    HOST_READ <= READ_REQ && (LOAD_ALLOWED || ASLEEP);
    if (HOST_READ_DUMMY === 1'b1) dropped <= dropped + 1;
  end
endmodule // bsrs_host_model

// >>> dv/tb_boot_sleep_reset_sequencer.sv
`timescale 1ns/1ps
module tb_boot_sleep_reset_sequencer;
  import bsrs_pkg::*;
  localparam int SC = 6;
  localparam int BC = 8;
  localparam int WC = 5;
  logic REF_CLK = 1'b0, NRST = 1'b0, OTG_IDENTITY_PIN = 1'b1, OTG_BUS_SUPPLY_PIN = 1'b0;
  logic EXTERNAL_IRQ_LINE = 1'b0, USB_RESUME = 1'b0, READ_REQ = 1'b0, SLEEP_SET = 1'b0;
  logic USB_BUS_RESET = 1'b0, ACCESS_WRITE = 1'b0, USB_HOST_ROLE = 1'b0, HOST_READ;
  logic [1:0] STRAP_IN = 2'h0, HOST_ADDR = 2'h0, BOOT_MODE, ACCESS_REGION;
  logic [4:0] WAKE_ENABLE = 5'h0;
  logic [3:0] CPU_SPEED = 4'hf, HOST_PORT_SELECT;
  logic [15:0] ACCESS_ADDR = 16'h0, START_PC;
  logic [2:0] HOST_IF_ENABLE, OTHER_PORTS_HOST;
  logic [31:0] PIN_OUT_ENABLE_N;
  logic BOOT_DONE, STANDALONE, LOAD_ALLOWED, FIRST_USB_PORT_HOST, ASLEEP, CLOCKS_ON;
  logic MEM_ADDR_LOW, CPU_RUN, CPU_TICK, HOST_PORT_IRQ_OUT, HOST_READ_DUMMY, USB_REG_CLEAR;
  logic ACCESS_ALT_DECODE, irq_seen = 1'b0, dummy_seen = 1'b0;
  int err_total = 0, num_checks = 0, m, n, k, c;
  int addrs[$] = '{0, 'h4a2, 'h4a3, 'hbfff, 'hc000, 'hc0ff, 'hc100, 'hdfff, 'he000, 'hffff};

  bsrs_seq #(.BOOT_CYCLES(BC), .START_CYCLES(SC), .WAKE_CYCLES(WC)) dut_u (
    .REF_CLK(REF_CLK), .NRST(NRST), .STRAP_IN(STRAP_IN), .OTG_IDENTITY_PIN(OTG_IDENTITY_PIN),
    .OTG_BUS_SUPPLY_PIN(OTG_BUS_SUPPLY_PIN), .EXTERNAL_IRQ_LINE(EXTERNAL_IRQ_LINE), .USB_RESUME(USB_RESUME),
    .HOST_READ(HOST_READ), .HOST_ADDR(HOST_ADDR), .SLEEP_SET(SLEEP_SET), .WAKE_ENABLE(WAKE_ENABLE),
    .CPU_SPEED(CPU_SPEED), .USB_BUS_RESET(USB_BUS_RESET), .ACCESS_ADDR(ACCESS_ADDR),
    .ACCESS_WRITE(ACCESS_WRITE), .USB_HOST_ROLE(USB_HOST_ROLE), .BOOT_MODE(BOOT_MODE), .BOOT_DONE(BOOT_DONE),
    .STANDALONE(STANDALONE), .HOST_IF_ENABLE(HOST_IF_ENABLE), .LOAD_ALLOWED(LOAD_ALLOWED),
    .PIN_OUT_ENABLE_N(PIN_OUT_ENABLE_N), .FIRST_USB_PORT_HOST(FIRST_USB_PORT_HOST),
    .OTHER_PORTS_HOST(OTHER_PORTS_HOST), .ASLEEP(ASLEEP), .CLOCKS_ON(CLOCKS_ON), .MEM_ADDR_LOW(MEM_ADDR_LOW),
    .CPU_RUN(CPU_RUN), .CPU_TICK(CPU_TICK), .START_PC(START_PC), .HOST_PORT_IRQ_OUT(HOST_PORT_IRQ_OUT),
    .HOST_READ_DUMMY(HOST_READ_DUMMY), .HOST_PORT_SELECT(HOST_PORT_SELECT), .USB_REG_CLEAR(USB_REG_CLEAR),
    .ACCESS_REGION(ACCESS_REGION), .ACCESS_ALT_DECODE(ACCESS_ALT_DECODE));
  bsrs_host_model host_u (.REF_CLK(REF_CLK), .LOAD_ALLOWED(LOAD_ALLOWED), .ASLEEP(ASLEEP),
    .HOST_READ_DUMMY(HOST_READ_DUMMY), .READ_REQ(READ_REQ), .HOST_READ(HOST_READ));

  always #25 REF_CLK = !REF_CLK;

  always @(negedge REF_CLK)
  begin
    if (HOST_PORT_IRQ_OUT === 1'b1) irq_seen = 1'b1;
    if (HOST_READ_DUMMY === 1'b1) dummy_seen = 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [1:0] region(input int a);
    if (a <= 'h4a2) return 2'h1;
    if (a >= 'hc000 && a <= 'hc0ff) return 2'h2;
    if (a >= 'he000) return 2'h3;
    return 2'h0;
  endfunction

  // Edge sources toggle, so every call is a fresh edge.
  task automatic fire(input int src);
    case (src)
      0: USB_RESUME = 1'b1;
      1: OTG_BUS_SUPPLY_PIN = 1'b1;
      2: OTG_IDENTITY_PIN = !OTG_IDENTITY_PIN;
      3: READ_REQ = 1'b1;
      default: EXTERNAL_IRQ_LINE = !EXTERNAL_IRQ_LINE;
    endcase
    @(negedge REF_CLK);
    USB_RESUME = 1'b0;
    READ_REQ = 1'b0;
  endtask

  initial
  begin
    #(50 * 5000);
    err_total++;
    complete_run;
  end

  initial
  begin
    void'($urandom(32'hfb404d3b));
    for (m = 0; m < 4; m++)
    begin
      NRST = 1'b0;
      STRAP_IN = m[1:0];
      repeat (m == 0 ? 20 : 28) @(negedge REF_CLK);
      NRST = 1'b1;
      for (n = 0; n < SC + BC + 4 && BOOT_DONE !== 1'b1; n++)
      begin
        @(negedge REF_CLK);
        if (n == 3) chk(START_PC, 16'hff00);
        if (n == 5) STRAP_IN = 2'($urandom);
        if (n == SC + 3) chk(PIN_OUT_ENABLE_N & TEST_OUT_MASK, 32'h0);
      end
      chk(n >= SC + BC && n < SC + BC + 4, 1'b1);
      chk(LOAD_ALLOWED, m != 3);
      chk(BOOT_MODE, m);
      chk(STANDALONE, m == 3);
      chk(HOST_IF_ENABLE, m == 3 ? 0 : 1 << m);
      chk(START_PC, 16'he000);
      if (m != 3) chk(PIN_OUT_ENABLE_N & STRAP_MASK, STRAP_MASK);
    end
    chk(PIN_OUT_ENABLE_N, ~(STRAP_MASK | UART_MASK));
    chk({FIRST_USB_PORT_HOST, OTHER_PORTS_HOST}, 4'h0);
    for (m = 0; m < 3; m++)
    begin
      CPU_SPEED = m == 0 ? 4'h0 : 4'($urandom);
      repeat (20) @(negedge REF_CLK);
      c = 0;
      repeat (4 * (CPU_SPEED + 1))
      begin
        @(negedge REF_CLK);
        c += CPU_TICK;
      end
      chk(c, 4);
    end
    repeat (6) addrs.push_back($urandom_range(65535));
    foreach (addrs[i])
    begin
      ACCESS_ADDR = addrs[i][15:0];
      ACCESS_WRITE = 1'($urandom);
      USB_HOST_ROLE = 1'($urandom);
      HOST_ADDR = 2'(i);
      USB_BUS_RESET = i[0];
      #1;
      chk(ACCESS_REGION, region(addrs[i]));
      chk(HOST_PORT_SELECT, 4'h1 << HOST_ADDR);
      chk(USB_REG_CLEAR, USB_BUS_RESET);
      chk(ACCESS_ALT_DECODE && (region(addrs[i]) != 2'h2 || !(ACCESS_WRITE || USB_HOST_ROLE)), 1'b0);
      @(negedge REF_CLK);
    end
    for (k = 0; k < 5; k++)
    begin
      WAKE_ENABLE = 5'h0;
      OTG_BUS_SUPPLY_PIN = 1'b0;
      SLEEP_SET = 1'b1;
      @(negedge REF_CLK);
      SLEEP_SET = 1'b0;
      chk({ASLEEP, CLOCKS_ON, MEM_ADDR_LOW, CPU_RUN}, 4'ha);
      chk(PIN_OUT_ENABLE_N, ~(STRAP_MASK | UART_MASK));
      fire(k);
      repeat (8) @(negedge REF_CLK);
      chk(ASLEEP, 1'b1);
      irq_seen = 1'b0;
      dummy_seen = 1'b0;
      WAKE_ENABLE = 5'(1 << k);
      if (k != 1) fire(k);
      for (n = 0; n < 8 && ASLEEP !== 1'b0; n++) @(negedge REF_CLK);
      chk(ASLEEP, 1'b0);
      for (n = 0; n < WC + 4 && CPU_RUN !== 1'b1; n++) @(negedge REF_CLK);
      chk(n >= WC - 1 && n < WC + 4, 1'b1);
      if (k == 0) chk(irq_seen, 1'b1);
      if (k == 3) chk(dummy_seen, 1'b1);
      OTG_BUS_SUPPLY_PIN = 1'b0;
      OTG_IDENTITY_PIN = k == 2 ? 1'b0 : OTG_IDENTITY_PIN;
      repeat (6) @(negedge REF_CLK);
      chk(FIRST_USB_PORT_HOST, !OTG_IDENTITY_PIN);
    end
    complete_run;
  end
endmodule // tb_boot_sleep_reset_sequencer
